// >>> logic/usb_endpoint_nak_control.sv
// Endpoint NAK control: NAK-all for endpoint 0, bank/NAK/DMA control for bulk and send-bit control for interrupt
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - NAK-all bit forces NAK on every non-SETUP endpoint 0 transaction.
// - Firmware writes to NAK-all wait while the engine reads request data.
// - During EP0 transfer, setting NAK-all applies only at reset, SETUP or status.
// - With EP0 idle, setting NAK-all applies right after the write.
// - Clearing NAK-all applies at once except during IN token NAK reply.
// - Bulk-OUT NAK bits are writable only when their write-enable bit is 1.
// - FIFO clear updates status within five clocks; firmware waits four clocks.
// - Bulk-OUT NAK writes ignored while NAK sent on EP0 read, EP2 or EP4.
// - Interrupt send bit sets on full buffer or end mark, clears on buffer clear.
// - Bulk-OUT NAK sets when engine bank cannot accept, clears on toggle.
// - Bulk-OUT banks swap when engine bank holds good data and CPU count is 0.
// - Firmware-set bulk-OUT NAK holds until firmware clears it or buffer clears; code also clears it on a bank toggle (out_tog).
// - Bulk-IN send bit sets on toggle; data held until sent correctly.
// - Bulk-IN swap needs CPU write complete and engine count 0; clear resets bit.
// - DMA fill without auto-toggle waits for end mark before toggling.
// - Enabling DMA during programmed I/O raises the DMA request at once.
// - Bulk-OUT DMA request drops on last CPU-side byte read or terminal count.
// - Bulk-IN DMA request drops after 64 bytes, returns on toggle unless masked.
// - Bulk-IN terminal count drops and masks the DMA request.
module usb_endpoint_nak_control
   import nak_ctrl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Engine side
   input  wire logic        bus_reset,
   input  wire logic        setup_pid,
   input  wire logic        status_stage,
   input  wire logic        ep0_xfer_done,
   input  wire logic        eng_req_read,
   input  wire logic        in_token_nak,
   input  wire logic        ep0_read_nak,
   input  wire bulk_evt_s   bulk_evt,
   input  wire logic [1:0]  intr_tx_done,
   // CPU/DMA data side: byte strobes and counts per buffer
   input  wire logic [1:0]  intr_wr_full,
   input  wire logic [1:0]  bulk_out_cpu_empty,
   input  wire logic [1:0]  bulk_out_last_rd,
   input  wire logic [1:0]  bulk_in_cpu_full,
   input  wire logic [1:0]  bulk_in_dma_wr,
   input  wire logic [1:0]  bulk_in_eng_empty,
   input  wire logic [1:0]  dma_tc,
   output logic             ep0_force_nak,
   output logic      [1:0]  bulk_out_bank,
   output logic      [1:0]  bulk_in_bank,
   output logic      [1:0]  dma_req_out,
   output logic      [1:0]  dma_req_in
);
   //////////////////////////////////////////////////////////////////////////////////////////////
   logic       nak_all;
   logic       nak_all_pend;
   logic       nak_all_val;
   logic [7:0] ep_nak;
   logic [1:0] out_wr_en;
   logic [1:0] in_auto_tog;
   logic [1:0] in_cpu_done;
   logic [1:0] out_eng_full;
   logic [1:0] in_mask;
   logic [1:0] dma_en_out;
   logic [1:0] dma_en_in;
   logic [1:0] out_clr_p;
   logic [1:0] in_clr_p;
   logic [1:0] int_clr_p;
   logic [1:0] int_end_p;
   logic [1:0] in_end_p;
   logic [1:0] out_tog;
   logic [1:0] in_tog;
   logic [6:0] in_dma_cnt [2];
   logic [2:0] clr_dly;
   logic [5:0] clr_hold;
   ep0_stage_e ep0_stage;
   logic       seen_setup;
   logic       wr_acc;
   logic       rd_acc;
   logic [11:0] a;
   logic       bulk_nak_busy;

   assign a       = paddr[11:0];
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign bulk_nak_busy = ep0_read_nak || |(out_eng_full & ~bulk_out_cpu_empty);

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Endpoint 0 stage tracking
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ep0_stage  <= EP0_IDLE;
         seen_setup <= 1'b0;
      end
      else if (bus_reset)
      begin
         ep0_stage  <= EP0_IDLE;
         seen_setup <= 1'b0;
      end
      else if (setup_pid)
      begin
         ep0_stage  <= EP0_DATA;
         seen_setup <= 1'b1;
      end
      else if (status_stage)
         ep0_stage <= EP0_STATUS;
      else if (ep0_xfer_done)
         ep0_stage <= EP0_IDLE;
   end

   // Pending write is parked until the engine lets go; never a torn value for the engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nak_all      <= RST_NAK_ALL[BIT_NAK_ALL];
         nak_all_pend <= 1'b0;
         nak_all_val  <= 1'b0;
      end
      else
      begin
         if (wr_acc && a == ADDR_NAK_ALL)
         begin
            nak_all_pend <= 1'b1;
            nak_all_val  <= pwdata[BIT_NAK_ALL];
         end
         else if (nak_all_pend && !eng_req_read)
         begin
            if (!nak_all_val && !in_token_nak)
            begin
               nak_all      <= 1'b0;
               nak_all_pend <= 1'b0;
            end
            else if (nak_all_val && (ep0_stage == EP0_IDLE || !seen_setup
                     || setup_pid || status_stage))
            begin
               nak_all      <= 1'b1;
               nak_all_pend <= 1'b0;
            end
         end
      end
   end

   assign ep0_force_nak = nak_all && !setup_pid;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Firmware controls: write mask, auto toggle, end marks, clears, DMA enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_wr_en   <= RST_MASK[1:0];
         in_auto_tog <= 2'h0;
         dma_en_out  <= 2'h0;
         dma_en_in   <= 2'h0;
      end
      else if (wr_acc)
      begin
         if (a == ADDR_WR_MASK)
            out_wr_en <= pwdata[3:2];
         else if (a == ADDR_DATA_END)
            in_auto_tog <= pwdata[7:6];
         else if (a == ADDR_DMA_CTRL)
         begin
            dma_en_out <= pwdata[1:0];
            dma_en_in  <= pwdata[3:2];
         end
      end
   end

   // One-cycle strobes from writes to data-end and FIFO-clear registers
   always_comb
   begin
      int_end_p = 2'h0;
      in_end_p  = 2'h0;
      int_clr_p = 2'h0;
      in_clr_p  = 2'h0;
      out_clr_p = 2'h0;
      if (wr_acc && a == ADDR_DATA_END)
      begin
         int_end_p = pwdata[5:4];
         in_end_p  = pwdata[1:0];
      end
      if (clr_dly == 3'h1)
      begin
         int_clr_p = clr_hold[5:4];
         out_clr_p = clr_hold[3:2];
         in_clr_p  = clr_hold[1:0];
      end
   end

   // Clear is applied inside the settle window so status is true when firmware looks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clr_dly  <= 3'h0;
         clr_hold <= 6'h00;
      end
      else if (wr_acc && a == ADDR_FIFO_CLEAR)
      begin
         clr_dly  <= CLR_SETTLE_CYC;
         clr_hold <= pwdata[5:0];
      end
      else if (clr_dly != 3'h0)
         clr_dly <= clr_dly - 3'h1;
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Per-endpoint bank, NAK and DMA request logic
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ep
         logic out_rx_ok;
         logic in_tx_ok;
         assign out_rx_ok = g ? bulk_evt.ok_rx_b : bulk_evt.ok_rx_a;
         assign in_tx_ok  = g ? bulk_evt.tx_done_b : bulk_evt.tx_done_a;
         assign out_tog[g] = out_eng_full[g] && bulk_out_cpu_empty[g];
         assign in_tog[g]  = in_cpu_done[g] && bulk_in_eng_empty[g];

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               out_eng_full[g]  <= 1'b0;
               bulk_out_bank[g] <= 1'b0;
            end
            else if (out_tog[g])
            begin
               out_eng_full[g]  <= 1'b0;
               bulk_out_bank[g] <= ~bulk_out_bank[g];
            end
            else if (out_rx_ok)
               out_eng_full[g] <= 1'b1;
            else if (out_clr_p[g])
               out_eng_full[g] <= 1'b0;
         end

         // Held data stays in the engine bank until acknowledged
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               in_cpu_done[g]  <= 1'b0;
               bulk_in_bank[g] <= 1'b0;
            end
            else if (in_tog[g])
            begin
               in_cpu_done[g]  <= 1'b0;
               bulk_in_bank[g] <= ~bulk_in_bank[g];
            end
            else if (in_end_p[g] || (bulk_in_cpu_full[g]
                     && (in_auto_tog[g] || !dma_en_in[g])))
               in_cpu_done[g] <= 1'b1;
            else if (in_clr_p[g])
               in_cpu_done[g] <= 1'b0;
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               in_dma_cnt[g] <= 7'h00;
            else if (in_tog[g] || in_clr_p[g])
               in_dma_cnt[g] <= 7'h00;
            else if (bulk_in_dma_wr[g] && in_dma_cnt[g] != BANK_BYTES)
               in_dma_cnt[g] <= in_dma_cnt[g] + 7'h01;
         end

         // Terminal count masks further IN requests until firmware unmasks
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               in_mask[g] <= 1'b0;
            else if (dma_en_in[g] && dma_tc[g])
               in_mask[g] <= 1'b1;
            else if (wr_acc && a == ADDR_DMA_CTRL && pwdata[4 + g])
               in_mask[g] <= 1'b0;
         end

         // Requests are level-derived so enabling DMA asserts them immediately
         assign dma_req_out[g] = dma_en_out[g] && !bulk_out_cpu_empty[g]
                                 && !bulk_out_last_rd[g] && !dma_tc[g];
         assign dma_req_in[g]  = dma_en_in[g] && !in_mask[g] && !dma_tc[g]
                                 && in_dma_cnt[g] != BANK_BYTES && !in_cpu_done[g];
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Endpoint NAK register; hardware set beats firmware or clear on the same edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ep_nak <= RST_EP_NAK;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            // Interrupt IN
            if (intr_wr_full[i] || int_end_p[i])
               ep_nak[BIT_INTR_A + i] <= 1'b1;
            else if (int_clr_p[i] || intr_tx_done[i])
               ep_nak[BIT_INTR_A + i] <= 1'b0;
            // Bulk OUT
            if (out_eng_full[i] && !bulk_out_cpu_empty[i])
               ep_nak[BIT_BULK_OUT_A + i] <= 1'b1;
            else if (out_tog[i] || out_clr_p[i])
               ep_nak[BIT_BULK_OUT_A + i] <= 1'b0;
            else if (wr_acc && a == ADDR_EP_NAK && out_wr_en[i] && !bulk_nak_busy)
               ep_nak[BIT_BULK_OUT_A + i] <= pwdata[BIT_BULK_OUT_A + i];
            // Bulk IN
            if (in_tog[i])
               ep_nak[BIT_BULK_IN_A + i] <= 1'b1;
            else if (in_clr_p[i])
               ep_nak[BIT_BULK_IN_A + i] <= 1'b0;
         end
         ep_nak[7:6] <= 2'h0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Read path, registered data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= 1'b0;
         if (pwrite)
            prdata <= 32'h00000000;
         else if (a == ADDR_NAK_ALL)
            prdata <= {31'h00000000, nak_all};
         else if (a == ADDR_EP_NAK)
            prdata <= {24'h000000, ep_nak};
         else if (a == ADDR_WR_MASK)
            prdata <= {28'h0000000, out_wr_en, 2'h0};
         else if (a == ADDR_DATA_END)
            prdata <= {24'h000000, in_auto_tog, 6'h00};
         else if (a == ADDR_DMA_CTRL)
            prdata <= {26'h0000000, in_mask, dma_en_in, dma_en_out};
         else if (a == ADDR_BANK_STAT)
            prdata <= {24'h000000, bulk_in_bank, bulk_out_bank, in_cpu_done, out_eng_full};
         else if (a == ADDR_FIFO_CLEAR)
            prdata <= 32'h00000000;
         else
         begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   a_nak_all_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && a == ADDR_NAK_ALL && !pwdata[0] && !eng_req_read && !in_token_nak)
      ##1 (!eng_req_read && !in_token_nak) |=> !nak_all)
      else $error("NAK-all clear not applied");
   a_nak_all_defer: assert property (@(posedge pclk) disable iff (!presetn)
      eng_req_read |=> $stable(nak_all))
      else $error("NAK-all changed during engine read");
   a_nak_all_gate: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(nak_all) |-> $past(ep0_stage == EP0_IDLE || !seen_setup || setup_pid
      || status_stage))
      else $error("NAK-all set outside allowed points");
   a_out_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && a == ADDR_EP_NAK && !out_wr_en[0] && !out_tog[0] && !out_clr_p[0]
      && !(out_eng_full[0] && !bulk_out_cpu_empty[0])) |=> $stable(ep_nak[2]))
      else $error("Masked bulk-OUT NAK write applied");
   a_in_tog_set: assert property (@(posedge pclk) disable iff (!presetn)
      in_tog[0] |=> ep_nak[0] && (bulk_in_bank[0] != $past(bulk_in_bank[0])))
      else $error("Bulk-IN toggle did not set send bit");
   a_out_tog_cond: assert property (@(posedge pclk) disable iff (!presetn)
      (bulk_out_bank[0] != $past(bulk_out_bank[0])) |-> $past(bulk_out_cpu_empty[0]))
      else $error("Bulk-OUT swap with CPU bank busy");
   a_clr_settle: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && a == ADDR_FIFO_CLEAR && pwdata[0]) |-> ##[1:5] in_clr_p[0])
      else $error("FIFO clear not applied in five clocks");
   a_dma_tc_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (dma_en_in[0] && dma_tc[0]) |=> (in_mask[0] && !dma_req_in[0]))
      else $error("Terminal count did not mask IN DMA");
   a_ep7_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ep_nak[7:6] == 2'h0)
      else $error("Unused NAK bits set");
endmodule

// >>> logic/nak_ctrl_pkg.sv
// Package: register map, field positions, reset values and timing for the endpoint NAK block
package nak_ctrl_pkg;
   // Register byte addresses (index times four, printed offsets are not word aligned)
   localparam logic [31:0] IDX_NAK_ALL     = 32'hFFFFFE01;
   localparam logic [31:0] IDX_EP_NAK      = 32'h0FFFFE02;
   localparam logic [11:0] ADDR_NAK_ALL    = {IDX_NAK_ALL[9:0], 2'b00};
   localparam logic [11:0] ADDR_EP_NAK     = {IDX_EP_NAK[9:0], 2'b00};
   localparam logic [11:0] ADDR_WR_MASK    = 12'h00C;
   localparam logic [11:0] ADDR_DATA_END   = 12'h010;
   localparam logic [11:0] ADDR_FIFO_CLEAR = 12'h014;
   localparam logic [11:0] ADDR_DMA_CTRL   = 12'h018;
   localparam logic [11:0] ADDR_BANK_STAT  = 12'h01C;
   // Field positions of endpoint_nak_control
   localparam int BIT_INTR_B     = 5;
   localparam int BIT_INTR_A     = 4;
   localparam int BIT_BULK_OUT_B = 3;
   localparam int BIT_BULK_OUT_A = 2;
   localparam int BIT_BULK_IN_B  = 1;
   localparam int BIT_BULK_IN_A  = 0;
   localparam int BIT_NAK_ALL    = 0;
   // Reset values
   localparam logic [7:0] RST_NAK_ALL = 8'h00;
   localparam logic [7:0] RST_EP_NAK  = 8'h00;
   localparam logic [7:0] RST_MASK    = 8'h00;
   // Bank size and FIFO-clear settle time
   localparam logic [6:0] BANK_BYTES      = 7'h40;
   localparam int         CLR_SETTLE_USB  = 5;
   localparam logic [2:0] CLR_SETTLE_CYC  = 3'(CLR_SETTLE_USB - 1);

   typedef enum logic [1:0] {
      EP0_IDLE   = 2'b00,
      EP0_DATA   = 2'b01,
      EP0_STATUS = 2'b11
   } ep0_stage_e;

   // Engine-side events for both bulk endpoint pairs (A and B)
   typedef struct packed {
      logic ok_rx_b;   // Correct packet landed in engine bank, endpoint 4
      logic ok_rx_a;   // Endpoint 2
      logic tx_done_b; // IN packet acknowledged, endpoint 3
      logic tx_done_a; // Endpoint 1
   } bulk_evt_s;
endpackage

// >>> verif/usb_host_model.sv
// Engine-side partner model: token events and NAK reply levels seen by the block
`timescale 1ns/1ns
module usb_host_model
   import nak_ctrl_pkg::*;
(
   input  wire logic        pclk,
   output logic             bus_reset,
   output logic             setup_pid,
   output logic             status_stage,
   output logic             ep0_xfer_done,
   output logic             eng_req_read,
   output logic             in_token_nak,
   output logic             ep0_read_nak,
   output bulk_evt_s        bulk_evt,
   output logic      [1:0]  intr_tx_done
);
   initial
   begin
      {bus_reset, setup_pid, status_stage, ep0_xfer_done} = 4'h0;
      {eng_req_read, in_token_nak, ep0_read_nak} = 3'h0;
      bulk_evt = '0;
      intr_tx_done = 2'h0;
   end
   // Events last exactly one clock, as the engine issues them
   task automatic evt(input logic [9:0] p);
      @(posedge pclk);
      {bus_reset, setup_pid, status_stage, ep0_xfer_done, bulk_evt, intr_tx_done} <= p;
      @(posedge pclk);
      {bus_reset, setup_pid, status_stage, ep0_xfer_done, bulk_evt, intr_tx_done} <= 10'h000;
   endtask
   // Levels: request read, IN token NAK reply, endpoint 0 read NAK
   task automatic lvl(input logic [2:0] l);
      @(posedge pclk);
      {eng_req_read, in_token_nak, ep0_read_nak} <= l;
   endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the endpoint NAK control block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb
   import nak_ctrl_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, q, d;
   logic        bus_reset, setup_pid, status_stage, ep0_xfer_done;
   logic        eng_req_read, in_token_nak, ep0_read_nak, ep0_force_nak;
   bulk_evt_s   bulk_evt;
   logic [1:0]  intr_tx_done, intr_wr_full, bulk_out_cpu_empty, bulk_out_last_rd;
   logic [1:0]  bulk_in_cpu_full, bulk_in_dma_wr, bulk_in_eng_empty, dma_tc;
   logic [1:0]  bulk_out_bank, bulk_in_bank, dma_req_out, dma_req_in, b;
   logic [15:0] seed;
   int          n_fail, total_checks;

   usb_endpoint_nak_control dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_reset(bus_reset), .setup_pid(setup_pid), .status_stage(status_stage),
      .ep0_xfer_done(ep0_xfer_done), .eng_req_read(eng_req_read),
      .in_token_nak(in_token_nak), .ep0_read_nak(ep0_read_nak), .bulk_evt(bulk_evt),
      .intr_tx_done(intr_tx_done), .intr_wr_full(intr_wr_full),
      .bulk_out_cpu_empty(bulk_out_cpu_empty), .bulk_out_last_rd(bulk_out_last_rd),
      .bulk_in_cpu_full(bulk_in_cpu_full), .bulk_in_dma_wr(bulk_in_dma_wr),
      .bulk_in_eng_empty(bulk_in_eng_empty), .dma_tc(dma_tc),
      .ep0_force_nak(ep0_force_nak), .bulk_out_bank(bulk_out_bank),
      .bulk_in_bank(bulk_in_bank), .dma_req_out(dma_req_out), .dma_req_in(dma_req_in));

   usb_host_model host_u (
      .pclk(pclk), .bus_reset(bus_reset), .setup_pid(setup_pid),
      .status_stage(status_stage), .ep0_xfer_done(ep0_xfer_done),
      .eng_req_read(eng_req_read), .in_token_nak(in_token_nak),
      .ep0_read_nak(ep0_read_nak), .bulk_evt(bulk_evt), .intr_tx_done(intr_tx_done));

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   //////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Only the low bit of the NAK-all register holds state
   function automatic logic [31:0] nak_all_exp(input logic [31:0] v);
      return {31'h0, v[BIT_NAK_ALL]};
   endfunction
   // Interrupt send bits: a fill beats a send-done seen on the same edge
   function automatic logic [1:0] intr_exp(input logic [1:0] s, f, dn);
      return f | (s & ~dn);
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {20'h0, a};
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(q, e)
      `CHK(err, 1'b0)
   endtask
   task automatic stop_test();
      if (n_fail == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      stop_test();
   end
   //////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {intr_wr_full, bulk_out_last_rd, bulk_in_cpu_full, bulk_in_dma_wr} = 8'h00;
      {bulk_in_eng_empty, dma_tc} = 4'h0;
      bulk_out_cpu_empty = 2'b11;
      seed = 16'h3A72;
      n_fail = 0;
      total_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(ADDR_NAK_ALL, {24'h0, RST_NAK_ALL});
      chk_rd(ADDR_EP_NAK, {24'h0, RST_EP_NAK});
      chk_rd(ADDR_WR_MASK, {24'h0, RST_MASK});
      apb(1'b0, 12'h020, 32'h0);
      `CHK(err, 1'b1)
      // No SETUP seen yet, so every write lands at once
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         d = (i == 0) ? 32'h0000_00FE : {24'h0, seed[7:0]};
         wr(ADDR_NAK_ALL, d);
         chk_rd(ADDR_NAK_ALL, nak_all_exp(d));
         `CHK(ep0_force_nak, d[0])
      end
      wr(ADDR_NAK_ALL, 32'h1);
      host_u.lvl(3'b010);
      wr(ADDR_NAK_ALL, 32'h0);
      chk_rd(ADDR_NAK_ALL, 32'h1);
      host_u.lvl(3'b000);
      chk_rd(ADDR_NAK_ALL, 32'h0);
      host_u.lvl(3'b100);
      wr(ADDR_NAK_ALL, 32'h1);
      chk_rd(ADDR_NAK_ALL, 32'h0);
      host_u.lvl(3'b000);
      chk_rd(ADDR_NAK_ALL, 32'h1);
      wr(ADDR_NAK_ALL, 32'h0);
      host_u.evt(10'h100);
      wr(ADDR_NAK_ALL, 32'h1);
      chk_rd(ADDR_NAK_ALL, 32'h0);
      host_u.evt(10'h080);
      chk_rd(ADDR_NAK_ALL, 32'h1);
      wr(ADDR_NAK_ALL, 32'h0);
      host_u.evt(10'h200);
      wr(ADDR_NAK_ALL, 32'h1);
      chk_rd(ADDR_NAK_ALL, 32'h1);
      wr(ADDR_NAK_ALL, 32'h0);
      host_u.evt(10'h040);
      // Bulk-OUT NAK writes: mask, then endpoint 0 read NAK, then accepted
      wr(ADDR_EP_NAK, 32'h0C);
      chk_rd(ADDR_EP_NAK, 32'h00);
      wr(ADDR_WR_MASK, 32'h0C);
      chk_rd(ADDR_WR_MASK, 32'h0C);
      host_u.lvl(3'b001);
      wr(ADDR_EP_NAK, 32'h0C);
      chk_rd(ADDR_EP_NAK, 32'h00);
      host_u.lvl(3'b000);
      wr(ADDR_EP_NAK, 32'h0C);
      repeat (8) @(posedge pclk);
      chk_rd(ADDR_EP_NAK, 32'h0C);
      wr(ADDR_EP_NAK, 32'h08);
      chk_rd(ADDR_EP_NAK, 32'h08);
      wr(ADDR_FIFO_CLEAR, 32'h0C);
      repeat (4) @(posedge pclk);
      chk_rd(ADDR_EP_NAK, 32'h00);
      // Interrupt IN: full buffer, end mark, then clear
      intr_wr_full <= 2'b01;
      @(posedge pclk);
      intr_wr_full <= 2'b00;
      chk_rd(ADDR_EP_NAK, 32'h10);
      wr(ADDR_DATA_END, 32'h20);
      chk_rd(ADDR_EP_NAK, 32'h30);
      // Random interrupt traffic while engine levels and DMA strobes wander
      b = 2'b11;
      for (int i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         intr_wr_full <= seed[1:0];
         {bulk_out_last_rd, dma_tc} <= seed[7:4];
         host_u.evt({6'h00, seed[3:2], seed[9:8]});
         intr_wr_full <= 2'b00;
         b = intr_exp(b, seed[1:0], seed[9:8]);
         chk_rd(ADDR_EP_NAK, {26'h0, b, 4'h0});
         `CHK({ep0_force_nak, dma_req_out, dma_req_in}, 5'h00)
         host_u.lvl(seed[12:10]);
      end
      {bulk_out_last_rd, dma_tc} <= 4'h0;
      host_u.lvl(3'b000);
      wr(ADDR_FIFO_CLEAR, 32'h30);
      repeat (4) @(posedge pclk);
      chk_rd(ADDR_EP_NAK, 32'h00);
      // Bulk IN by PIO: no swap while the engine bank is busy
      bulk_in_cpu_full <= 2'b01;
      repeat (3) @(posedge pclk);
      `CHK(bulk_in_bank, 2'b00)
      bulk_in_eng_empty <= 2'b01;
      @(posedge pclk);
      bulk_in_cpu_full <= 2'b00;
      bulk_in_eng_empty <= 2'b00;
      @(negedge pclk);
      `CHK(bulk_in_bank, 2'b01)
      chk_rd(ADDR_EP_NAK, 32'h01);
      bulk_in_eng_empty <= 2'b01;
      wr(ADDR_DATA_END, 32'h01);
      repeat (2) @(negedge pclk);
      `CHK(bulk_in_bank, 2'b00)
      @(posedge pclk);
      bulk_in_eng_empty <= 2'b00;
      wr(ADDR_FIFO_CLEAR, 32'h01);
      repeat (4) @(posedge pclk);
      chk_rd(ADDR_EP_NAK, 32'h00);
      // Bulk OUT: swap needs good data and an empty CPU bank
      host_u.evt(10'h010);
      repeat (2) @(negedge pclk);
      `CHK(bulk_out_bank, 2'b01)
      @(posedge pclk);
      bulk_out_cpu_empty <= 2'b10;
      host_u.evt(10'h010);
      chk_rd(ADDR_EP_NAK, 32'h04);
      `CHK(bulk_out_bank, 2'b01)
      bulk_out_cpu_empty <= 2'b11;
      repeat (2) @(posedge pclk);
      `CHK(bulk_out_bank, 2'b00)
      chk_rd(ADDR_EP_NAK, 32'h00);
      // DMA out: request on enable, drops on last read and terminal count
      bulk_out_cpu_empty <= 2'b10;
      wr(ADDR_DMA_CTRL, 32'h01);
      @(negedge pclk);
      `CHK(dma_req_out, 2'b01)
      @(posedge pclk);
      bulk_out_last_rd <= 2'b01;
      @(negedge pclk);
      `CHK(dma_req_out[0], 1'b0)
      @(posedge pclk);
      bulk_out_last_rd <= 2'b00;
      dma_tc <= 2'b01;
      @(negedge pclk);
      `CHK(dma_req_out[0], 1'b0)
      @(posedge pclk);
      dma_tc <= 2'b00;
      bulk_out_cpu_empty <= 2'b11;
      wr(ADDR_DMA_CTRL, 32'h00);
      // DMA in: 64 bytes, held without auto-toggle until end mark, then TC
      b = bulk_in_bank;
      wr(ADDR_DMA_CTRL, 32'h14);
      @(negedge pclk);
      `CHK(dma_req_in, 2'b01)
      repeat (64) @(posedge pclk) bulk_in_dma_wr <= 2'b01;
      @(negedge pclk);
      `CHK(dma_req_in[0], 1'b1)
      @(posedge pclk);
      bulk_in_dma_wr <= 2'b00;
      @(negedge pclk);
      `CHK(dma_req_in[0], 1'b0)
      @(posedge pclk);
      bulk_in_cpu_full <= 2'b01;
      bulk_in_eng_empty <= 2'b01;
      repeat (4) @(posedge pclk);
      `CHK(bulk_in_bank, b)
      bulk_in_cpu_full <= 2'b00;
      wr(ADDR_DATA_END, 32'h01);
      repeat (2) @(negedge pclk);
      `CHK(bulk_in_bank, b ^ 2'b01)
      `CHK(dma_req_in[0], 1'b1)
      @(posedge pclk);
      bulk_in_eng_empty <= 2'b00;
      dma_tc <= 2'b01;
      @(negedge pclk);
      `CHK(dma_req_in[0], 1'b0)
      @(posedge pclk);
      dma_tc <= 2'b00;
      chk_rd(ADDR_DMA_CTRL, 32'h14);
      `CHK(dma_req_in[0], 1'b0)
      wr(ADDR_DMA_CTRL, 32'h14);
      @(negedge pclk);
      `CHK(dma_req_in[0], 1'b1)
      stop_test();
   end
endmodule
